// [design/rcl_top.sv]
// run command logic: decides final forward and backward run commands
// assumes all inputs synchronous to mclk_i; keys are one-cycle pulses
//
// Notes on behaviour
// - run key latches run on with keypad direction until stop key or timer expiry.
// - with three-wire hold asserted, momentary terminal runs are latched.
// - without hold assigned, terminal run inputs act as plain levels.
// - command word is 16 bits; bit 0 forward, bit 1 backward.
// - bits 13 and 14 act as run terminals per terminal function settings.
// - link gate is the OR of bits 0, 1, 13 and 14.
// - simultaneous forward and backward requests force both runs off.
// - stop priority 1 or 3: stop key clears runs, linear deceleration.
// - reference below start or stop frequency turns runs off.
// - reference below lower limit turns run off when so configured.
// - command loss with response 0 turns run off.
// - timer expiry turns run off and releases keypad latch together.
// - after overload stop, restart needs request off then on again.
// - reference negated for backward, zero when stopping.
// - direction limiter blocks the disallowed reference polarity.
// - output frequency clamped to upper limit, except while dc braking.
// - dc braking selects brake voltage and frequency values.
// - pid modes 1 or 2 invert error when inverse chosen.
// - pid mode: steps 1..3 to manual, 4, 8, 12 to pid command.
`timescale 1ns/100ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_top
  import rcl_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  // keypad
  input  wire logic                  key_run_i,
  input  wire logic                  key_stop_i,
  input  wire logic                  key_backward_i,
  // terminals
  input  wire logic                  term_fwd_i,
  input  wire logic                  term_bwd_i,
  input  wire logic                  hold_assigned_i,
  input  wire logic                  three_wire_latch_i,
  // communications word
  input  wire logic                  cmd_wr_i,
  input  wire logic           [15:0] cmd_data_i,
  output logic                [15:0] operation_command_word_o,
  output logic                       comms_link_gate_o,
  // settings
  input  wire rcl_pkg::rcl_src_t     run_src_i,
  input  wire rcl_pkg::rcl_term_fn_t first_run_terminal_function_i,
  input  wire rcl_pkg::rcl_term_fn_t second_run_terminal_function_i,
  input  wire logic            [1:0] stop_key_priority_i,
  input  wire logic            [1:0] accel_decel_pattern_i,
  input  wire logic           [15:0] starting_frequency_i,
  input  wire logic           [15:0] stop_frequency_i,
  input  wire logic           [15:0] lower_frequency_limit_i,
  input  wire logic                  lower_limit_action_i,
  input  wire logic            [2:0] command_loss_response_i,
  input  wire logic                  command_loss_i,
  input  wire logic                  timer_enable_i,
  input  wire logic    [TIMER_W-1:0] timer_preset_i,
  input  wire logic                  overload_stop_action_i,
  input  wire logic                  overload_i,
  // reference and output stage
  input  wire logic signed    [15:0] ref_freq_i,
  input  wire rcl_pkg::rcl_dir_lim_t direction_limiter_i,
  input  wire logic           [15:0] ramp_freq_i,
  input  wire logic           [15:0] upper_frequency_limit_i,
  input  wire logic                  dc_brake_i,
  input  wire logic           [15:0] dc_freq_i,
  input  wire logic           [15:0] dc_volt_i,
  input  wire logic           [15:0] norm_volt_i,
  // pid
  input  wire logic            [1:0] pid_mode_code_i,
  input  wire logic                  error_polarity_flip_i,
  input  wire logic signed    [15:0] pid_cmd_i,
  input  wire logic signed    [15:0] pid_fb_i,
  input  wire logic            [3:0] step_sel_i,
  // results
  output logic                       forward_run_cmd_o,
  output logic                       backward_run_cmd_o,
  output logic                       keypad_hold_o,
  output logic                       restart_lock_o,
  output logic                       linear_decel_o,
  output logic                 [1:0] decel_pattern_o,
  output logic signed         [15:0] final_ref_o,
  output logic                [15:0] out_freq_o,
  output logic                [15:0] out_volt_o,
  output logic signed         [15:0] pid_error_o,
  output logic                 [3:0] manual_step_o,
  output logic                 [3:0] pid_step_o
);

  // ==========================================================
  // state
  logic [15:0]        word_ff, nxt_word;
  logic               kp_hold_ff, nxt_kp_hold;
  logic               kp_bwd_ff, nxt_kp_bwd;
  logic               tw_fwd_ff, nxt_tw_fwd;
  logic               tw_bwd_ff, nxt_tw_bwd;
  logic               fwd_ff, nxt_fwd;
  logic               bwd_ff, nxt_bwd;
  logic               lock_ff, nxt_lock;
  logic               lin_ff, nxt_lin;
  logic               req_d_ff, nxt_req_d;
  logic signed [15:0] err_ff, nxt_err;
  logic [3:0]         man_ff, nxt_man;
  logic [3:0]         pstep_ff, nxt_pstep;

  // ==========================================================
  // combinational helpers
  logic        term_a, term_b;
  logic        word_fwd, word_bwd;
  logic        term_fwd, term_bwd;
  logic        req_fwd, req_bwd, req_any;
  logic        prio_stop;
  logic        ovl_stop;
  logic        freq_low;
  logic        loss_stop;
  logic        run_start;
  logic        tmr_expire;
  logic        tmr_running;
  logic [15:0] ref_mag;
  logic        pid_on, pid_inv;

  // ==========================================================
  // operation command word, written whole by the link
  always_comb begin
    nxt_word = cmd_wr_i ? cmd_data_i : word_ff;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) word_ff <= `RCL_CMD_RST;
    else          word_ff <= nxt_word;
  end

  assign operation_command_word_o = word_ff;

  // ==========================================================
  // word decode; a shared function on both bits ORs them together
  assign term_a   = word_ff[`RCL_CMD_TERM_A_BIT];
  assign term_b   = word_ff[`RCL_CMD_TERM_B_BIT];
  assign word_fwd = word_ff[`RCL_CMD_FWD_BIT]
    | (term_a && first_run_terminal_function_i  == RCL_FN_FORWARD)
    | (term_b && second_run_terminal_function_i == RCL_FN_FORWARD);
  assign word_bwd = word_ff[`RCL_CMD_BWD_BIT]
    | (term_a && first_run_terminal_function_i  == RCL_FN_BACKWARD)
    | (term_b && second_run_terminal_function_i == RCL_FN_BACKWARD);
  assign comms_link_gate_o = term_a | term_b
    | word_ff[`RCL_CMD_FWD_BIT] | word_ff[`RCL_CMD_BWD_BIT];

  // ==========================================================
  // terminal inputs: three-wire latch or two-wire levels
  always_comb begin
    nxt_tw_fwd = 1'b0;
    nxt_tw_bwd = 1'b0;
    if (hold_assigned_i && three_wire_latch_i) begin
      nxt_tw_fwd = tw_fwd_ff | term_fwd_i;
      nxt_tw_bwd = tw_bwd_ff | term_bwd_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tw_fwd_ff <= 1'b0;
      tw_bwd_ff <= 1'b0;
    end else begin
      tw_fwd_ff <= nxt_tw_fwd;
      tw_bwd_ff <= nxt_tw_bwd;
    end
  end

  // momentary pulses count in the latch cycle itself
  assign term_fwd = hold_assigned_i
    ? (tw_fwd_ff | term_fwd_i) & three_wire_latch_i
    : term_fwd_i;
  assign term_bwd = hold_assigned_i
    ? (tw_bwd_ff | term_bwd_i) & three_wire_latch_i
    : term_bwd_i;

  // ==========================================================
  // keypad hold; stop key and timer expiry both release it
  always_comb begin
    nxt_kp_hold = kp_hold_ff;
    nxt_kp_bwd  = kp_bwd_ff;
    if (key_run_i) begin
      nxt_kp_hold = 1'b1;
      nxt_kp_bwd  = key_backward_i;
    end
    if (key_stop_i || tmr_expire)
      nxt_kp_hold = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kp_hold_ff <= 1'b0;
      kp_bwd_ff  <= 1'b0;
    end else begin
      kp_hold_ff <= nxt_kp_hold;
      kp_bwd_ff  <= nxt_kp_bwd;
    end
  end

  assign keypad_hold_o = kp_hold_ff;

  // ==========================================================
  // request from the selected source
  always_comb begin
    case (run_src_i)
      RCL_SRC_KEYPAD: begin
        req_fwd = kp_hold_ff & ~kp_bwd_ff;
        req_bwd = kp_hold_ff &  kp_bwd_ff;
      end
      RCL_SRC_TERMINAL: begin
        req_fwd = term_fwd;
        req_bwd = term_bwd;
      end
      RCL_SRC_COMMS: begin
        req_fwd = word_fwd;
        req_bwd = word_bwd;
      end
      default: begin
        req_fwd = 1'b0;
        req_bwd = 1'b0;
      end
    endcase
  end

  assign req_any = req_fwd | req_bwd;

  // ==========================================================
  // stop conditions
  assign prio_stop = key_stop_i &&
    (stop_key_priority_i == `RCL_STOP_PRIO_A ||
     stop_key_priority_i == `RCL_STOP_PRIO_B);
  assign ovl_stop  = overload_i & overload_stop_action_i;
  assign ref_mag   = ref_freq_i[15] ? 16'(-ref_freq_i) : ref_freq_i;
  // magnitude compare: direction does not lower the threshold
  assign freq_low  = (ref_mag < starting_frequency_i)
                   | (ref_mag < stop_frequency_i)
                   | (lower_limit_action_i &&
                      ref_mag < lower_frequency_limit_i);
  assign loss_stop = command_loss_i &&
    command_loss_response_i == `RCL_LOSS_STOP;
  assign run_start = req_any & ~req_d_ff;

  // ==========================================================
  // restart lock: set by overload stop, priority 1 or 3 stop key or timer expiry; released only
  // once the request drops; set wins over the release
  always_comb begin
    nxt_lock = lock_ff;
    if (!req_any) nxt_lock = 1'b0;
    if (ovl_stop || prio_stop || tmr_expire) nxt_lock = 1'b1;
    nxt_req_d = req_any;
    nxt_lin = lin_ff;
    if (run_start) nxt_lin = 1'b0;
    if (prio_stop) nxt_lin = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_ff  <= 1'b0;
      req_d_ff <= 1'b0;
      lin_ff   <= 1'b0;
    end else begin
      lock_ff  <= nxt_lock;
      req_d_ff <= nxt_req_d;
      lin_ff   <= nxt_lin;
    end
  end

  assign restart_lock_o  = lock_ff;
  assign linear_decel_o  = lin_ff;
  assign decel_pattern_o = lin_ff ? `RCL_PAT_LINEAR : accel_decel_pattern_i;

  // ==========================================================
  // timer driven operation
  rcl_timer #(
    .WIDTH     (TIMER_W)
  ) u_timer (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (run_start & timer_enable_i),
    .abort_i   (~req_any | ~timer_enable_i),
    .preset_i  (timer_preset_i),
    .running_o (tmr_running),
    .expire_o  (tmr_expire)
  );

  // ==========================================================
  // final run decision, registered every cycle
  always_comb begin
    nxt_fwd = req_fwd;
    nxt_bwd = req_bwd;
    if (req_fwd && req_bwd) begin
      nxt_fwd = 1'b0;
      nxt_bwd = 1'b0;
    end
    if (lock_ff || prio_stop || ovl_stop || tmr_expire ||
        freq_low || loss_stop) begin
      nxt_fwd = 1'b0;
      nxt_bwd = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_ff <= 1'b0;
      bwd_ff <= 1'b0;
    end else begin
      fwd_ff <= nxt_fwd;
      bwd_ff <= nxt_bwd;
    end
  end

  assign forward_run_cmd_o  = fwd_ff;
  assign backward_run_cmd_o = bwd_ff;

  // ==========================================================
  // output stage
  rcl_freq u_freq (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .fwd_i         (fwd_ff),
    .bwd_i         (bwd_ff),
    .ref_mag_i     (ref_mag),
    .dir_lim_i     (direction_limiter_i),
    .ramp_freq_i   (ramp_freq_i),
    .upper_limit_i (upper_frequency_limit_i),
    .dc_brake_i    (dc_brake_i),
    .dc_freq_i     (dc_freq_i),
    .dc_volt_i     (dc_volt_i),
    .norm_volt_i   (norm_volt_i),
    .final_ref_o   (final_ref_o),
    .out_freq_o    (out_freq_o),
    .out_volt_o    (out_volt_o)
  );

  // ==========================================================
  // pid process mode: error polarity and step routing
  assign pid_on  = pid_mode_code_i == `RCL_PID_NORMAL ||
                   pid_mode_code_i == `RCL_PID_INVERSE;
  // mode code and inversion input toggle each other
  assign pid_inv = (pid_mode_code_i == `RCL_PID_INVERSE)
                 ^ error_polarity_flip_i;

  always_comb begin
    nxt_err   = `RCL_FREQ_RST;
    nxt_man   = step_sel_i;
    nxt_pstep = 4'h0;
    if (pid_on) begin
      nxt_err   = pid_inv ? 16'(pid_fb_i - pid_cmd_i)
                          : 16'(pid_cmd_i - pid_fb_i);
      nxt_man   = step_sel_i & `RCL_STEP_MANUAL;
      nxt_pstep = step_sel_i & `RCL_STEP_PID;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_ff   <= `RCL_FREQ_RST;
      man_ff   <= 4'h0;
      pstep_ff <= 4'h0;
    end else begin
      err_ff   <= nxt_err;
      man_ff   <= nxt_man;
      pstep_ff <= nxt_pstep;
    end
  end

  assign pid_error_o   = err_ff;
  assign manual_step_o = man_ff;
  assign pid_step_o    = pstep_ff;

endmodule : rcl_top

`default_nettype wire

// [common/rcl_regs.svh]
// constants of the run command logic: bit positions, codes, reset values
// assumes inclusion by bare name from any file that needs them
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH

// ==========================================================
// operation command word layout
`define RCL_CMD_FWD_BIT    4'h0
`define RCL_CMD_BWD_BIT    4'h1
`define RCL_CMD_TERM_A_BIT 4'hD
`define RCL_CMD_TERM_B_BIT 4'hE
`define RCL_CMD_RST        16'h0000

// ==========================================================
// setting codes
`define RCL_STOP_PRIO_A    2'h1
`define RCL_STOP_PRIO_B    2'h3
`define RCL_LOSS_STOP      3'h0
`define RCL_PID_NORMAL     2'h1
`define RCL_PID_INVERSE    2'h2
`define RCL_PAT_LINEAR     2'h0
`define RCL_STEP_MANUAL    4'h3
`define RCL_STEP_PID       4'hC

// ==========================================================
// reset values
`define RCL_FREQ_RST       16'h0000
`define RCL_TIMER_RST      16'h0000

`endif

// [common/rcl_pkg.sv]
// types shared by the run command logic files
// assumes nothing beyond a SystemVerilog compiler
package rcl_pkg;

  // ========================================================
  // run command source
  typedef enum logic [1:0] {
    RCL_SRC_KEYPAD,
    RCL_SRC_TERMINAL,
    RCL_SRC_COMMS
  } rcl_src_t;

  // ========================================================
  // function given to a run terminal and its word bit
  typedef enum logic [1:0] {
    RCL_FN_NONE,
    RCL_FN_FORWARD,
    RCL_FN_BACKWARD
  } rcl_term_fn_t;

  // ========================================================
  // rotation direction limiter setting
  typedef enum logic [1:0] {
    RCL_DIR_FREE,
    RCL_DIR_NO_FORWARD,
    RCL_DIR_NO_BACKWARD
  } rcl_dir_lim_t;

endpackage : rcl_pkg

// [design/rcl_timer.sv]
// countdown timer for timer driven operation
// assumes start is a one-cycle pulse at the rising edge of a run command
`timescale 1ns/100ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic             abort_i,
  input  wire logic [WIDTH-1:0] preset_i,
  output logic                  running_o,
  output logic                  expire_o
);

  logic [WIDTH-1:0] count_ff, nxt_count;
  logic             run_ff, nxt_run;
  logic             exp_ff, nxt_exp;

  // ==========================================================
  // countdown; a zero preset expires on the next cycle
  always_comb begin
    nxt_count = count_ff;
    nxt_run   = run_ff;
    nxt_exp   = 1'b0;
    if (abort_i) begin
      nxt_run = 1'b0;
    end else if (start_i) begin
      nxt_count = preset_i;
      nxt_run   = 1'b1;
    end else if (run_ff) begin
      if (count_ff == '0) begin
        nxt_run = 1'b0;
        nxt_exp = 1'b1;
      end else begin
        nxt_count = count_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_ff <= WIDTH'(`RCL_TIMER_RST);
      run_ff   <= 1'b0;
      exp_ff   <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      run_ff   <= nxt_run;
      exp_ff   <= nxt_exp;
    end
  end

  assign running_o = run_ff;
  assign expire_o  = exp_ff;

endmodule : rcl_timer

`default_nettype wire

// [design/rcl_freq.sv]
// output stage: sign, zero, direction limiter, upper clamp, dc brake mux
// assumes run commands already settled by the decision logic
`timescale 1ns/100ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_freq
  import rcl_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               fwd_i,
  input  wire logic               bwd_i,
  input  wire logic signed [15:0] ref_mag_i,
  input  wire rcl_pkg::rcl_dir_lim_t dir_lim_i,
  input  wire logic        [15:0] ramp_freq_i,
  input  wire logic        [15:0] upper_limit_i,
  input  wire logic               dc_brake_i,
  input  wire logic        [15:0] dc_freq_i,
  input  wire logic        [15:0] dc_volt_i,
  input  wire logic        [15:0] norm_volt_i,
  output logic signed      [15:0] final_ref_o,
  output logic             [15:0] out_freq_o,
  output logic             [15:0] out_volt_o
);

  logic signed [15:0] ref_ff, nxt_ref;
  logic        [15:0] frq_ff, nxt_frq;
  logic        [15:0] vlt_ff, nxt_vlt;

  // ==========================================================
  // signed reference, then polarity limiter, then clamp and brake mux
  always_comb begin
    nxt_ref = `RCL_FREQ_RST;
    if (fwd_i) nxt_ref = ref_mag_i;
    if (bwd_i) nxt_ref = 16'(-ref_mag_i);
    if (dir_lim_i == RCL_DIR_NO_FORWARD && nxt_ref > 0)
      nxt_ref = `RCL_FREQ_RST;
    if (dir_lim_i == RCL_DIR_NO_BACKWARD && nxt_ref < 0)
      nxt_ref = `RCL_FREQ_RST;
    nxt_frq = (ramp_freq_i > upper_limit_i) ? upper_limit_i
                                            : ramp_freq_i;
    nxt_vlt = norm_volt_i;
    if (dc_brake_i) begin
      nxt_frq = dc_freq_i;
      nxt_vlt = dc_volt_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_ff <= `RCL_FREQ_RST;
      frq_ff <= `RCL_FREQ_RST;
      vlt_ff <= `RCL_FREQ_RST;
    end else begin
      ref_ff <= nxt_ref;
      frq_ff <= nxt_frq;
      vlt_ff <= nxt_vlt;
    end
  end

  assign final_ref_o = ref_ff;
  assign out_freq_o  = frq_ff;
  assign out_volt_o  = vlt_ff;

endmodule : rcl_freq

`default_nettype wire

// [verif/rcl_chk.sv]
// checker: port-level rules of the run command logic
// assumes it is bound onto rcl_top, a single clock domain
`timescale 1ns/100ps
`default_nettype none
module rcl_chk (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        key_stop_i,
  input  wire logic  [1:0] stop_key_priority_i,
  input  wire logic        cmd_wr_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic [15:0] operation_command_word_o,
  input  wire logic        comms_link_gate_o,
  input  wire logic        command_loss_i,
  input  wire logic  [2:0] command_loss_response_i,
  input  wire logic        overload_i,
  input  wire logic        overload_stop_action_i,
  input  wire logic        forward_run_cmd_o,
  input  wire logic        backward_run_cmd_o,
  input  wire logic        linear_decel_o,
  input  wire logic  [1:0] decel_pattern_o,
  input  wire logic signed [15:0] final_ref_o
);
  // ========================================================
  // run command relations
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // readback must carry the whole written word
  word_load_a: assert property (cmd_wr_i |=>
    operation_command_word_o == $past(cmd_data_i)) else $error("word lost");
  link_gate_a: assert property (comms_link_gate_o ==
    |{operation_command_word_o[14:13], operation_command_word_o[1:0]})
    else $error("link gate wrong");
  run_excl_a: assert property (
    !(forward_run_cmd_o && backward_run_cmd_o)) else $error("both runs on");
  // priority codes 1 and 3 are the two with bit 0 set
  key_stop_a: assert property (
    key_stop_i && stop_key_priority_i[0] |=> !forward_run_cmd_o &&
    !backward_run_cmd_o) else $error("stop key ignored");
  lin_decel_a: assert property (
    linear_decel_o |-> decel_pattern_o == 2'h0) else $error("not linear");
  loss_stop_a: assert property (
    command_loss_i && command_loss_response_i == 3'h0 |=>
    !forward_run_cmd_o && !backward_run_cmd_o) else $error("loss ignored");
  ovl_stop_a: assert property (
    overload_i && overload_stop_action_i |=> !forward_run_cmd_o &&
    !backward_run_cmd_o) else $error("overload ignored");
  stop_zero_a: assert property (
    !forward_run_cmd_o && !backward_run_cmd_o |=> final_ref_o == 16'sh0000)
    else $error("stopped reference not zero");
endmodule : rcl_chk
bind rcl_top rcl_chk u_chk (.*);
`default_nettype wire

// [verif/rcl_host.sv]
// host model: writes the operation command word over the link port
// assumes the bench calls send at a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module rcl_host (
  input  wire logic        mclk_i,
  output logic             cmd_wr_o,
  output logic      [15:0] cmd_data_o
);
  // ========================================================
  // word writer
  initial cmd_wr_o = 1'b0;
  initial cmd_data_o = 16'h0000;
  // whole word per strobe; data inverted once released
  task automatic send(input logic [15:0] w);
    cmd_wr_o = 1'b1;
    cmd_data_o = w;
    @(negedge mclk_i);
    cmd_wr_o = 1'b0;
    cmd_data_o = ~w;
  endtask : send
endmodule : rcl_host
`default_nettype wire

// [verif/rcl_top_tb_top.sv]
// bench: drives rcl_top by keypad, terminals and host model
// assumes rcl_pkg compiled first; inputs change at falling edges
`timescale 1ns/100ps
`default_nettype none
module rcl_top_tb_top;
  import rcl_pkg::*;
  // ========================================================
  // ports
  logic mclk_i = '0, rst_n_i = '0, key_run_i = '0, key_stop_i = '0;
  logic key_backward_i = '0, term_fwd_i = '0, term_bwd_i = '0;
  logic hold_assigned_i = '0, three_wire_latch_i = '0, command_loss_i = '0;
  logic lower_limit_action_i = '0, timer_enable_i = '0, overload_i = '0;
  logic overload_stop_action_i = 1'h1, dc_brake_i = '0;
  logic error_polarity_flip_i = '0, cmd_wr_i, comms_link_gate_o;
  logic forward_run_cmd_o, backward_run_cmd_o, keypad_hold_o;
  logic restart_lock_o, linear_decel_o;
  logic [1:0] stop_key_priority_i = '0, accel_decel_pattern_i = 2'h2;
  logic [1:0] pid_mode_code_i = '0, decel_pattern_o;
  logic [2:0] command_loss_response_i = '0;
  logic [3:0] step_sel_i = '0, manual_step_o, pid_step_o;
  logic [15:0] starting_frequency_i = 16'h0010, stop_frequency_i = 16'h0010;
  logic [15:0] lower_frequency_limit_i = 16'h0020, timer_preset_i = 16'h0005;
  logic [15:0] ramp_freq_i = 16'h0300, upper_frequency_limit_i = 16'h0200;
  logic [15:0] dc_freq_i = 16'h0055, dc_volt_i = 16'h0066;
  logic [15:0] norm_volt_i = 16'h0077, out_freq_o, out_volt_o;
  logic [15:0] cmd_data_i, operation_command_word_o;
  logic signed [15:0] ref_freq_i = 16'sh0100, pid_cmd_i = '0, pid_fb_i = '0;
  logic signed [15:0] final_ref_o, pid_error_o;
  rcl_src_t     run_src_i = RCL_SRC_TERMINAL;
  rcl_term_fn_t first_run_terminal_function_i = RCL_FN_FORWARD;
  rcl_term_fn_t second_run_terminal_function_i = RCL_FN_BACKWARD;
  rcl_dir_lim_t direction_limiter_i = RCL_DIR_FREE;
  int fails = 0;
  int num_checks = 0;
  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;
  rcl_top u_dut (.*);
  rcl_host u_host (.mclk_i(mclk_i), .cmd_wr_o(cmd_wr_i),
    .cmd_data_o(cmd_data_i));
  // ========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : step
  task automatic runs(input logic f, input logic b);
    chk({14'h0, forward_run_cmd_o, backward_run_cmd_o}, {14'h0, f, b});
  endtask : runs
  task automatic pulse(ref logic k);
    k = 1'b1;
    step(1);
    k = 1'b0;
  endtask : pulse
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ========================================================
  // scenarios
  task automatic t_keypad();
    run_src_i = RCL_SRC_KEYPAD;
    key_backward_i = 1'b1;
    pulse(key_run_i);
    step(4);
    runs(1'b0, 1'b1);
    chk(final_ref_o, 16'hFF00);
    pulse(key_stop_i);
    step(1);
    runs(1'b0, 1'b0);
    step(1);
    chk(final_ref_o, 16'h0000);
  endtask : t_keypad
  task automatic t_wire();
    run_src_i = RCL_SRC_TERMINAL;
    term_fwd_i = 1'b1;
    step(2);
    runs(1'b1, 1'b0);
    chk(final_ref_o, 16'h0100);
    term_fwd_i = 1'b0;
    step(1);
    runs(1'b0, 1'b0);
    hold_assigned_i = 1'b1;
    three_wire_latch_i = 1'b1;
    pulse(term_bwd_i);
    step(2);
    runs(1'b0, 1'b1);
    term_fwd_i = 1'b1;
    step(1);
    runs(1'b0, 1'b0);
    term_fwd_i = 1'b0;
    three_wire_latch_i = 1'b0;
    hold_assigned_i = 1'b0;
    step(2);
  endtask : t_wire
  // both priority codes; the request is dropped to lift the lock
  task automatic t_prio();
    for (int i = 0; i < 2; i++) begin
      stop_key_priority_i = i ? 2'h3 : 2'h1;
      term_fwd_i = 1'b1;
      step(2);
      pulse(key_stop_i);
      runs(1'b0, 1'b0);
      chk({14'h0, decel_pattern_o}, 16'h0000);
      step(2);
      runs(1'b0, 1'b0);
      term_fwd_i = 1'b0;
      step(2);
    end
  endtask : t_prio
  task automatic t_word();
    logic [15:0] w[6] = '{16'h0001, 16'h0002, 16'h2000, 16'h4000,
                          16'h0003, 16'h8004};
    logic [2:0]  e[6] = '{3'h6, 3'h5, 3'h6, 3'h5, 3'h4, 3'h0};
    run_src_i = RCL_SRC_COMMS;
    foreach (w[i]) begin
      u_host.send(w[i]);
      chk(operation_command_word_o, w[i]);
      chk({15'h0, comms_link_gate_o}, {15'h0, e[i][2]});
      step(1);
      runs(e[i][1], e[i][0]);
    end
  endtask : t_word
  task automatic t_guard();
    run_src_i = RCL_SRC_TERMINAL;
    term_fwd_i = 1'b1;
    ref_freq_i = 16'sh0008;
    step(2);
    runs(1'b0, 1'b0);
    ref_freq_i = 16'sh0018;
    step(1);
    runs(1'b1, 1'b0);
    lower_limit_action_i = 1'b1;
    step(1);
    runs(1'b0, 1'b0);
    ref_freq_i = 16'sh0100;
    command_loss_i = 1'b1;
    step(1);
    runs(1'b0, 1'b0);
    command_loss_response_i = 3'h1;
    step(1);
    runs(1'b1, 1'b0);
    pulse(overload_i);
    step(2);
    runs(1'b0, 1'b0);
    chk({15'h0, restart_lock_o}, 16'h0001);
    term_fwd_i = 1'b0;
    step(2);
    term_fwd_i = 1'b1;
    step(2);
    runs(1'b1, 1'b0);
  endtask : t_guard
  task automatic t_timer();
    run_src_i = RCL_SRC_KEYPAD;
    timer_enable_i = 1'b1;
    key_backward_i = 1'b0;
    pulse(key_run_i);
    step(3);
    runs(1'b1, 1'b0);
    step(12);
    runs(1'b0, 1'b0);
    chk({15'h0, keypad_hold_o}, 16'h0000);
  endtask : t_timer
  task automatic t_out();
    step(2);
    chk(out_freq_o, 16'h0200);
    dc_brake_i = 1'b1;
    step(2);
    chk(out_freq_o, 16'h0055);
    chk(out_volt_o, 16'h0066);
    dc_brake_i = 1'b0;
    step(2);
    chk(out_volt_o, 16'h0077);
  endtask : t_out
  // forward run from the terminal, limiter and pid mode 2
  task automatic t_pid();
    run_src_i = RCL_SRC_TERMINAL;
    timer_enable_i = 1'b0;
    direction_limiter_i = RCL_DIR_NO_FORWARD;
    pid_mode_code_i = 2'h2;
    pid_cmd_i = 16'sh0030;
    step_sel_i = 4'hF;
    step(3);
    chk(final_ref_o, 16'h0000);
    chk(pid_error_o, 16'hFFD0);
    chk({8'h0, manual_step_o, pid_step_o}, 16'h003C);
    error_polarity_flip_i = 1'b1;
    direction_limiter_i = RCL_DIR_NO_BACKWARD;
    step(2);
    chk(pid_error_o, 16'h0030);
    chk(final_ref_o, 16'h0100);
  endtask : t_pid
  // main sequence after 12 cycles of reset
  initial begin
    step(12);
    rst_n_i = 1'b1;
    t_keypad();
    t_wire();
    t_prio();
    t_word();
    t_guard();
    t_timer();
    t_out();
    t_pid();
    print_verdict();
  end
  // watchdog: run needs about 95 cycles
  initial begin
    #50000;
    fails++;
    print_verdict();
  end
endmodule : rcl_top_tb_top
`default_nettype wire
